// ---- design/bfhc_pkg.sv ----
// Package for the boot flash host controller: pin group, ops, timing
package bfhc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DATA_W = 16;
  // Bus cycle phase times in ns
  localparam int unsigned T_SETUP_NS = 20;
  localparam int unsigned T_STROBE_NS = 70;
  localparam int unsigned T_HOLD_NS = 20;
  localparam int unsigned T_RESET_NS = 150;
  localparam int unsigned T_WAKE_NS = 150;
  // Least times round up to whole cycles
  localparam int unsigned SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RESET_CYC = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_CYC = (T_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  // Block layout of the device
  localparam int unsigned PARAM_BLOCKS = 8;
  localparam int unsigned PARAM_WORDS = 4096;
  localparam int unsigned MAIN_WORDS = 32768;
  localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00ff;
  // Identifier address: A0 selects, A1 and up held at zero
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 22'h000000;
  localparam logic [ADDR_W-1:0] ID_DEVICE_ADDR = 22'h000001;
  // Host operation codes
  typedef enum logic [1:0] {
    BFHC_OP_READ,
    BFHC_OP_WRITE,
    BFHC_OP_RESET
  } bfhc_op_t;
  // Flash pin group driven by the controller
  typedef struct packed {
    logic reset_powerdown_n;
    logic chip_sel_n;
    logic out_en_n;
    logic write_en_n;
    logic write_protect_n;
    logic [ADDR_W-1:0] addr;
  } bfhc_pins_t;
endpackage

// ---- design/bfhc_timer.sv ----
// Down counter that paces the phases of each bus cycle
`timescale 1ns/1ps
module bfhc_timer
  import bfhc_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  initial begin
    if (WIDTH < 2) begin
      $error("bfhc_timer width too small");
    end
  end

  // Load wins over counting so a new phase never inherits the old count
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Done looks at the count only; the sequencer loads on done, so
  // gating done by load would close a combinational loop
  assign done = (cnt_reg == '0);
endmodule

// ---- design/bfhc_host.sv ----
// Host controller that runs read, write and reset cycles on a NOR flash
`timescale 1ns/1ps
module bfhc_host
  import bfhc_pkg::*;
#(
  parameter int unsigned BYTE_WIDE = 0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire bfhc_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_unlock,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output bfhc_pins_t flash_pins,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_i
);
  typedef enum {
    ST_POR, ST_WAKE, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RESET
  } bfhc_state_t;

  bfhc_state_t state_reg, state_next;
  bfhc_op_t op_reg, op_next;
  bfhc_pins_t pins_reg, pins_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic ready_reg, ready_next;
  logic rv_reg, rv_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [DATA_W-1:0] sync1_reg, sync2_reg;
  logic t_load;
  logic [CNT_W-1:0] t_value;
  logic t_done;

  initial begin
    if (BYTE_WIDE > 1) begin
      $error("BYTE_WIDE must be 0 or 1");
    end
    if (WAKE_CYC >= (1 << CNT_W) || RESET_CYC >= (1 << CNT_W)) begin
      $error("Timer too narrow for phase counts");
    end
  end

  // Byte-wide parts leave the upper data lines unused
  function automatic logic [DATA_W-1:0] lane_mask(input logic [DATA_W-1:0] d);
    lane_mask = (BYTE_WIDE != 0) ? (d & BYTE_MASK) : d;
  endfunction

  bfhc_timer #(.WIDTH(CNT_W)) u_timer (
    .clk(clk),
    .rstn(rstn),
    .load(t_load),
    .value(t_value),
    .done(t_done)
  );

  // Read data comes from the pins, so it is synchronised before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= data_lines_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Cycle sequencer; strobes never overlap so no invalid combination forms
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    pins_next = pins_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    ready_next = 1'b0;
    rv_next = 1'b0;
    rdata_next = rdata_reg;
    t_load = 1'b0;
    t_value = '0;
    case (state_reg)
      ST_POR: begin
        // Timer resets to zero, so load the full reset time before counting
        state_next = ST_RESET;
        t_load = 1'b1;
        t_value = CNT_W'(RESET_CYC);
      end
      ST_WAKE: begin
        // Device returns to array reads alone; just wait out wake time
        if (t_done) begin
          state_next = ST_IDLE;
          ready_next = 1'b1;
        end
      end
      ST_IDLE: begin
        ready_next = 1'b1;
        if (req_valid && ready_reg) begin
          ready_next = 1'b0;
          op_next = req_op;
          pins_next.addr = req_addr;
          // Lockable blocks need write protect high for the whole cycle
          pins_next.write_protect_n = req_unlock;
          if (req_op == BFHC_OP_RESET) begin
            pins_next.reset_powerdown_n = 1'b0;
            state_next = ST_RESET;
            t_load = 1'b1;
            t_value = CNT_W'(RESET_CYC);
          end else begin
            pins_next.chip_sel_n = 1'b0;
            // Host drives data lines only for writes, with output enable high
            // Read modes change through a written command word or a reset
            if (req_op == BFHC_OP_WRITE) begin
              dout_next = lane_mask(req_wdata);
              oe_next = 1'b1;
            end
            state_next = ST_SETUP;
            t_load = 1'b1;
            t_value = CNT_W'(SETUP_CYC);
          end
        end
      end
      ST_SETUP: begin
        if (t_done) begin
          if (op_reg == BFHC_OP_WRITE) begin
            pins_next.write_en_n = 1'b0;
          end else begin
            pins_next.out_en_n = 1'b0;
          end
          state_next = ST_STROBE;
          t_load = 1'b1;
          t_value = CNT_W'(STROBE_CYC);
        end
      end
      ST_STROBE: begin
        if (t_done) begin
          if (op_reg == BFHC_OP_READ) begin
            rdata_next = lane_mask(sync2_reg);
            rv_next = 1'b1;
          end
          // Rising strobe latches the command or data in the device
          pins_next.write_en_n = 1'b1;
          pins_next.out_en_n = 1'b1;
          state_next = ST_HOLD;
          t_load = 1'b1;
          t_value = CNT_W'(HOLD_CYC);
        end
      end
      ST_HOLD: begin
        if (t_done) begin
          pins_next.chip_sel_n = 1'b1;
          oe_next = 1'b0;
          state_next = ST_IDLE;
          ready_next = 1'b1;
        end
      end
      ST_RESET: begin
        if (t_done) begin
          pins_next.reset_powerdown_n = 1'b1;
          state_next = ST_WAKE;
          t_load = 1'b1;
          t_value = CNT_W'(WAKE_CYC);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Reset holds the device in reset-powerdown; release starts the reset time, then the wake wait
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_POR;
      op_reg <= BFHC_OP_READ;
      pins_reg <= '{reset_powerdown_n: 1'b0, chip_sel_n: 1'b1,
                    out_en_n: 1'b1, write_en_n: 1'b1,
                    write_protect_n: 1'b0, addr: '0};
      dout_reg <= '0;
      oe_reg <= 1'b0;
      ready_reg <= 1'b0;
      rv_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      pins_reg <= pins_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ready_reg <= ready_next;
      rv_reg <= rv_next;
      rdata_reg <= rdata_next;
    end
  end

  assign flash_pins = pins_reg;
  assign data_lines_o = dout_reg;
  assign data_lines_oe = oe_reg;
  assign req_ready = ready_reg;
  assign rsp_valid = rv_reg;
  assign rsp_rdata = rdata_reg;

  // Checks on the pin sequence
  a_no_invalid_mix: assert property (@(posedge clk) disable iff (!rstn)
    !(!pins_reg.chip_sel_n && !pins_reg.out_en_n && !pins_reg.write_en_n))
    else $error("All three strobes low");
  a_read_strobes: assert property (@(posedge clk) disable iff (!rstn)
    !pins_reg.out_en_n |-> !pins_reg.chip_sel_n && pins_reg.write_en_n &&
    pins_reg.reset_powerdown_n && !oe_reg)
    else $error("Bad read strobes");
  a_write_strobes: assert property (@(posedge clk) disable iff (!rstn)
    !pins_reg.write_en_n |-> !pins_reg.chip_sel_n && pins_reg.out_en_n &&
    oe_reg)
    else $error("Bad write strobes");
  a_reset_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !pins_reg.reset_powerdown_n |-> pins_reg.chip_sel_n && !oe_reg)
    else $error("Strobes active in reset");
  a_wp_steady: assert property (@(posedge clk) disable iff (!rstn)
    !pins_reg.chip_sel_n && !$past(pins_reg.chip_sel_n) |->
    $stable(pins_reg.write_protect_n))
    else $error("Write protect moved in cycle");
  a_addr_steady: assert property (@(posedge clk) disable iff (!rstn)
    !pins_reg.chip_sel_n && !$past(pins_reg.chip_sel_n) |->
    $stable(pins_reg.addr))
    else $error("Address moved in cycle");
  a_byte_lanes: assert property (@(posedge clk) disable iff (!rstn)
    (BYTE_WIDE != 0) |-> (dout_reg & ~BYTE_MASK) == '0 &&
    (rdata_reg & ~BYTE_MASK) == '0)
    else $error("Upper lanes used on byte part");
  a_read_answer: assert property (@(posedge clk) disable iff (!rstn)
    $fell(pins_reg.out_en_n) |-> ##[1:40] rsp_valid)
    else $error("Read not answered");
  a_float_deselect: assert property (@(posedge clk) disable iff (!rstn)
    pins_reg.chip_sel_n |-> !oe_reg && pins_reg.out_en_n)
    else $error("Driving while deselected");

  c_read: cover property (@(posedge clk) disable iff (!rstn) rsp_valid);
  c_write: cover property (@(posedge clk) disable iff (!rstn)
    $rose(pins_reg.write_en_n));
  c_reset: cover property (@(posedge clk) disable iff (!rstn)
    $rose(pins_reg.reset_powerdown_n));
endmodule

// ---- dv/bfhc_flash_model.sv ----
// Behavioural boot flash that answers the host controller's pin cycles
`timescale 1ns/1ps
module bfhc_flash_model
  import bfhc_pkg::*;
#(
  parameter int ACC_NS = 10,
  parameter logic [7:0] CMD_IDENT = 8'h90,
  parameter logic [7:0] CMD_STATUS = 8'h70,
  parameter logic [7:0] CMD_ERASE_OK = 8'h21, // Arbitrary confirm code
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h005a // Arbitrary value
) (
  input wire bfhc_pins_t pins,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic supply_ok,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);
  localparam logic [1:0] M_ARRAY = 2'h0;
  localparam logic [1:0] M_IDENT = 2'h1;
  localparam logic [1:0] M_STATUS = 2'h2;
  logic [1:0] mode_reg = M_ARRAY;
  logic prog_reg = 1'b0;
  logic erase_reg = 1'b0;
  logic [ADDR_W-1:0] wa [8];
  logic wp_seen_reg = 1'b0;
  logic [DATA_W-1:0] mem [8];
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] last_reg = '0;
  logic rd_en;
  // Read only with select and output enable low, strobe and reset high
  assign rd_en = pins.reset_powerdown_n && !pins.chip_sel_n &&
    !pins.out_en_n && pins.write_en_n;
  // Sparse store: low words of block 0, then words at block edges
  initial begin
    for (int i = 0; i < 8; i++) begin
      mem[i] = 16'h1000 + 16'(i);
      wa[i] = ADDR_W'(i);
    end
    wa[5] = ADDR_W'(PARAM_WORDS);
    wa[6] = ADDR_W'(PARAM_BLOCKS * PARAM_WORDS);
    wa[7] = ADDR_W'(PARAM_BLOCKS * PARAM_WORDS + MAIN_WORDS);
  end
  // Block number: small parameter blocks first, then equal main blocks
  function automatic int block_of(input logic [ADDR_W-1:0] a);
    int p;
    p = PARAM_BLOCKS * PARAM_WORDS;
    if (a < p) return a / PARAM_WORDS;
    return PARAM_BLOCKS + (a - p) / MAIN_WORDS;
  endfunction
  // Reset drops a pending program and returns to array reads
  always @(pins.reset_powerdown_n) begin
    if (!pins.reset_powerdown_n) begin
      mode_reg = M_ARRAY;
      prog_reg = 1'b0;
      erase_reg = 1'b0;
    end
  end
  // Latch on the rising strobe; output enable low makes it invalid
  always @(posedge pins.write_en_n) begin
    if (pins.reset_powerdown_n && !pins.chip_sel_n && pins.out_en_n) begin
      if (prog_reg) begin
        prog_reg = 1'b0;
        mode_reg = M_STATUS;
        wp_seen_reg = pins.write_protect_n;
        for (int i = 0; i < 8; i++) begin
          if (supply_ok && wa[i] == pins.addr) mem[i] = dq_in;
        end
      end else if (erase_reg) begin
        erase_reg = 1'b0;
        mode_reg = M_STATUS;
        // Only words of the addressed block are wiped
        for (int i = 0; i < 8; i++) begin
          if (supply_ok && dq_in[7:0] == CMD_ERASE_OK &&
              block_of(wa[i]) == block_of(pins.addr)) begin
            mem[i] = 16'hffff;
          end
        end
      end else begin
        case (dq_in[7:0])
          8'hff: mode_reg = M_ARRAY;
          CMD_IDENT: mode_reg = M_IDENT;
          CMD_STATUS: mode_reg = M_STATUS;
          8'h40: prog_reg = 1'b1;
          8'h20: erase_reg = 1'b1;
          default: ;
        endcase
      end
    end
  end
  // Word-wide part: all sixteen lines carry data
  always_comb begin
    case (mode_reg)
      M_IDENT: val = (pins.addr[ADDR_W-1:1] != '0) ? 16'h0000 :
        (pins.addr[0] ? DEVICE_CODE : MAKER_CODE);
      M_STATUS: val = 16'h0080;
      default: begin
        val = 16'hffff; // Unstored words read as erased
        for (int i = 0; i < 8; i++) begin
          if (wa[i] == pins.addr) val = mem[i];
        end
      end
    endcase
  end
  // Released lines show the inverse of the last value, so no stale match
  always @(val or rd_en) if (rd_en) last_reg = val;
  assign #(ACC_NS) dq_out = rd_en ? val : ~last_reg;
  assign #(ACC_NS) dq_oe = rd_en;
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the boot flash host controller
`timescale 1ns/1ps
module tb_top;
  import bfhc_pkg::*;
  localparam logic [15:0] MAKER = 16'h00c3; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h003c; // Arbitrary value
  logic clk = 0, rstn = 0, req_valid = 0, req_unlock = 0, supply_ok = 1;
  bfhc_op_t req_op = BFHC_OP_READ;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_lines_o;
  logic [DATA_W-1:0] data_lines_i, model_dq;
  logic req_ready, rsp_valid, data_lines_oe, model_oe;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] q8, rdata8, dlo8;
  logic oe8;
  bfhc_pins_t flash_pins;
  int fail_count = 0, n_tests = 0;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Host drive wins when enabled, else the model's level or float pattern
  assign data_lines_i = data_lines_oe ? data_lines_o : model_dq;
  bfhc_host DUT (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_unlock(req_unlock), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .flash_pins(flash_pins),
    .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
    .data_lines_i(data_lines_i));
  bfhc_flash_model #(.ACC_NS(15), .MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    FLASH (.pins(flash_pins), .dq_in(data_lines_o), .supply_ok(supply_ok),
    .dq_out(model_dq), .dq_oe(model_oe));
  // Byte-wide twin runs in lockstep on the same requests and read data
  bfhc_host #(.BYTE_WIDE(1)) DUT_BYTE (.clk(clk), .rstn(rstn),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_unlock(req_unlock), .req_ready(),
    .rsp_valid(), .rsp_rdata(rdata8), .flash_pins(),
    .data_lines_o(dlo8), .data_lines_oe(oe8), .data_lines_i(model_dq));
  task final_report;
    $display("mismatches %0d of %0d compares", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait at falling edges until the controller is idle
  task wait_ready;
    int i;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk);
    if (i == 200) begin
      fail_count++;
      final_report();
    end
  endtask
  // One request, held until taken; reads return the word
  task do_op(input bfhc_op_t op, input logic [ADDR_W-1:0] a,
             input logic [DATA_W-1:0] d, input logic unl);
    int i;
    wait_ready();
    req_valid = 1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_unlock = unl;
    @(negedge clk);
    req_valid = 0;
    @(negedge clk);
    if (op == BFHC_OP_READ) begin
      for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) @(negedge clk);
      if (i == 100) begin
        fail_count++;
        final_report();
      end
      q = rsp_rdata;
      q8 = rdata8;
    end
  endtask
  task t_boot;
    `CHK(flash_pins.reset_powerdown_n, 1'b0)
    do_op(BFHC_OP_READ, 22'h3, 16'h0, 0);
    `CHK(q, 16'h1003)
    `CHK(q8, 16'h0003)
    wait_ready();
    `CHK(flash_pins.chip_sel_n, 1'b1)
  endtask
  task t_program;
    do_op(BFHC_OP_WRITE, 22'h2, 16'h0040, 1);
    do_op(BFHC_OP_WRITE, 22'h2, 16'hbeef, 1);
    do_op(BFHC_OP_READ, 22'h0, 16'h0, 0);
    `CHK(q, 16'h0080)
    `CHK(FLASH.wp_seen_reg, 1'b1)
    do_op(BFHC_OP_WRITE, 22'h0, 16'h00ff, 0);
    do_op(BFHC_OP_READ, 22'h2, 16'h0, 0);
    `CHK(q, 16'hbeef)
    `CHK(q8, 16'h00ef)
  endtask
  // Erase one parameter and one main block; neighbours must survive
  task t_erase;
    do_op(BFHC_OP_WRITE, 22'h1000, 16'h0020, 1);
    do_op(BFHC_OP_WRITE, 22'h1000, 16'h0021, 1);
    do_op(BFHC_OP_WRITE, 22'h8000, 16'h0020, 1);
    do_op(BFHC_OP_WRITE, 22'h8000, 16'h0021, 1);
    do_op(BFHC_OP_WRITE, 22'h0, 16'h00ff, 0);
    do_op(BFHC_OP_READ, 22'h1000, 16'h0, 0);
    `CHK(q, 16'hffff)
    do_op(BFHC_OP_READ, 22'h4, 16'h0, 0);
    `CHK(q, 16'h1004)
    do_op(BFHC_OP_READ, 22'h8000, 16'h0, 0);
    `CHK(q, 16'hffff)
    do_op(BFHC_OP_READ, 22'h10000, 16'h0, 0);
    `CHK(q, 16'h1007)
  endtask
  // Supply below lockout: program must leave the word alone
  task t_lockout;
    supply_ok = 0;
    do_op(BFHC_OP_WRITE, 22'h4, 16'h0040, 1);
    do_op(BFHC_OP_WRITE, 22'h4, 16'hcafe, 1);
    do_op(BFHC_OP_WRITE, 22'h0, 16'h00ff, 0);
    do_op(BFHC_OP_READ, 22'h4, 16'h0, 0);
    `CHK(q, 16'h1004)
    supply_ok = 1;
  endtask
  task t_ident;
    do_op(BFHC_OP_WRITE, 22'h0, 16'h0090, 0);
    do_op(BFHC_OP_READ, ID_MAKER_ADDR, 16'h0, 0);
    `CHK(q, MAKER)
    do_op(BFHC_OP_READ, ID_DEVICE_ADDR, 16'h0, 0);
    `CHK(q, DEVICE)
    do_op(BFHC_OP_RESET, 22'h0, 16'h0, 0);
    do_op(BFHC_OP_READ, 22'h1, 16'h0, 0);
    `CHK(q, 16'h1001)
  endtask
  // Strobe combination and bus ownership watched every cycle
  always @(negedge clk) begin
    if (rstn) begin
      `CHK(~flash_pins.chip_sel_n & ~flash_pins.out_en_n & ~flash_pins.write_en_n, 1'b0)
      `CHK(data_lines_oe & model_oe, 1'b0)
      if (oe8) `CHK(dlo8 & 16'hff00, 16'h0000)
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1;
    t_boot();
    t_program();
    t_lockout();
    t_erase();
    t_ident();
    final_report();
  end
endmodule
